// >>> core/sssp_pkg.sv
package sssp_pkg;

    // register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // register offsets (word index on the register port)
    localparam logic [ADDR_W-1:0] ADDR_INT_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FLAGS     = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_ENABLES   = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PRIORITY  = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_RX_CTRL   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_TX_BUF    = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_TX_CTRL   = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_RATE_DIV  = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_RX_BUF    = 4'h8;

    // reset values
    localparam logic [DATA_W-1:0] RST_INT_CTRL   = 8'h00;
    localparam logic [DATA_W-1:0] RST_FLAGS      = 8'h00;
    localparam logic [DATA_W-1:0] RST_ENABLES    = 8'h00;
    localparam logic [DATA_W-1:0] RST_PRIORITY   = 8'h00;
    localparam logic [DATA_W-1:0] RST_RX_CTRL    = 8'h00;
    localparam logic [DATA_W-1:0] RST_TX_BUF     = 8'h00;
    localparam logic [DATA_W-1:0] RST_TX_CTRL    = 8'h02;
    localparam logic [DATA_W-1:0] RST_RATE_DIV   = 8'h00;
    localparam logic [DATA_W-1:0] RST_RX_BUF     = 8'h00;

    // field positions in the flag, enable and interrupt control registers
    localparam int BIT_RX_EVENT   = 5;
    localparam int BIT_TX_EVENT   = 4;
    localparam int BIT_GLOBAL_EN  = 7;
    localparam int BIT_PERIPH_EN  = 6;

    // word lengths in shift clock pulses
    localparam logic [3:0] WORD_BITS_EIGHT = 4'h8;
    localparam logic [3:0] WORD_BITS_NINE  = 4'h9;

    // transmit status and control layout, bit 7 first
    typedef struct packed {
        logic clock_source_select;
        logic transmit_ninth_bit_enable;
        logic transmit_enable;
        logic sync_mode;
        logic spare;
        logic high_rate;
        logic shifter_empty;
        logic transmit_ninth_bit_value;
    } sssp_txctl_s;

    // receive status and control layout, bit 7 first
    typedef struct packed {
        logic port_enable;
        logic receive_ninth_bit_enable;
        logic single_receive_enable;
        logic continuous_receive_enable;
        logic address_detect;
        logic framing_error_flag;
        logic overrun_error_flag;
        logic received_ninth_bit;
    } sssp_rxctl_s;

    // pins seen from the core clock
    typedef struct packed {
        logic shift_timing;
        logic serial_line;
    } sssp_pins_s;

endpackage

// >>> core/sssp_pin_sync.sv
`timescale 1ns/1ps
module sssp_pin_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clock,
    input  wire logic         rst_n,
    // pins from outside the clock domain
    input  wire logic [W-1:0] async_in,
    // synchronised level and edge pulses
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // meta_q feeds sync_q only; edges are taken between sync_q and prev_q
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = prev_q & ~sync_q;

endmodule

// >>> core/sssp_port.sv
`timescale 1ns/1ps
module sssp_port (
    // clock and reset
    input  wire logic                        clock,
    input  wire logic                        rst_n,
    // register port
    input  wire logic [sssp_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [sssp_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [sssp_pkg::DATA_W-1:0] reg_rdata,
    // core
    input  wire logic                        core_sleep,
    output logic                             irq,
    output logic                             wake,
    // pins
    input  wire logic                        shift_timing_pin,
    input  wire logic                        serial_line_in,
    output logic                             serial_line_out,
    output logic                             serial_line_oe
);

    // register state
    logic [sssp_pkg::DATA_W-1:0] int_ctrl_q;
    logic [sssp_pkg::DATA_W-1:0] flags_spare_q;
    logic [sssp_pkg::DATA_W-1:0] enables_q;
    logic [sssp_pkg::DATA_W-1:0] priority_q;
    logic [sssp_pkg::DATA_W-1:0] rate_div_q;
    sssp_pkg::sssp_txctl_s       txctl_q;
    sssp_pkg::sssp_rxctl_s       rxctl_q;
    logic [sssp_pkg::DATA_W-1:0] rd_data_q;

    // transmit path
    logic [8:0]                  txbuf_q;
    logic                        txbuf_full_q;
    logic                        transmit_buffer_empty_flag_q;
    logic [8:0]                  tsr_q;
    logic [3:0]                  tx_cnt_q;
    logic                        tx_busy_q;

    // receive path
    logic [8:0]                  rsr_q;
    logic [3:0]                  rx_cnt_q;
    logic [7:0]                  rxbuf_q;
    logic                        received_ninth_bit_q;
    logic                        receive_complete_flag_q;
    logic                        overrun_error_flag_q;

    // synchronised pins
    sssp_pkg::sssp_pins_s        pin_level;
    sssp_pkg::sssp_pins_s        pin_rise;
    sssp_pkg::sssp_pins_s        pin_fall;

    sssp_pin_sync #(
        .W        (2)
    ) u_pin_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .async_in ({shift_timing_pin, serial_line_in}),
        .level    (pin_level),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    // address decode
    wire wr_int_ctrl = reg_wr && (reg_addr == sssp_pkg::ADDR_INT_CTRL);
    wire wr_flags    = reg_wr && (reg_addr == sssp_pkg::ADDR_FLAGS);
    wire wr_enables  = reg_wr && (reg_addr == sssp_pkg::ADDR_ENABLES);
    wire wr_priority = reg_wr && (reg_addr == sssp_pkg::ADDR_PRIORITY);
    wire wr_rx_ctrl  = reg_wr && (reg_addr == sssp_pkg::ADDR_RX_CTRL);
    wire wr_tx_buf   = reg_wr && (reg_addr == sssp_pkg::ADDR_TX_BUF);
    wire wr_tx_ctrl  = reg_wr && (reg_addr == sssp_pkg::ADDR_TX_CTRL);
    wire wr_rate_div = reg_wr && (reg_addr == sssp_pkg::ADDR_RATE_DIV);
    wire rd_rx_buf   = reg_rd && (reg_addr == sssp_pkg::ADDR_RX_BUF);

    // mode selection; the shift timing pin is only ever an input here
    wire slave_mode  = txctl_q.sync_mode && rxctl_q.port_enable
                       && !txctl_q.clock_source_select;
    wire rx_on       = slave_mode && rxctl_q.continuous_receive_enable;
    // reception owns the data pin if software left the receive enable on
    wire tx_on       = slave_mode && txctl_q.transmit_enable && !rx_on;
    wire shift_fall  = pin_fall.shift_timing;

    // transmit path control
    wire load_go     = tx_on && txbuf_full_q && !tx_busy_q && !wr_tx_buf;
    wire tx_last     = tx_busy_q && shift_fall && (tx_cnt_q == 4'h1);
    wire [3:0] tx_len = txctl_q.transmit_ninth_bit_enable ? sssp_pkg::WORD_BITS_NINE
                                                          : sssp_pkg::WORD_BITS_EIGHT;

    // receive path control
    wire [3:0] rx_len = rxctl_q.receive_ninth_bit_enable ? sssp_pkg::WORD_BITS_NINE
                                                         : sssp_pkg::WORD_BITS_EIGHT;
    wire       rx_shift = rx_on && shift_fall;
    wire [8:0] rsr_next = {pin_level.serial_line, rsr_q[8:1]};
    wire       rx_done  = rx_shift && (rx_cnt_q == rx_len - 4'h1);
    // eight-bit words sit high in the shifter, nine-bit words fill it
    wire [7:0] rx_word  = rxctl_q.receive_ninth_bit_enable ? rsr_next[7:0] : rsr_next[8:1];
    wire       rx_unread = receive_complete_flag_q && !rd_rx_buf;
    wire       rx_take  = rx_done && !rx_unread;

    // interrupt requests
    wire tx_req      = transmit_buffer_empty_flag_q && enables_q[sssp_pkg::BIT_TX_EVENT];
    wire rx_req      = receive_complete_flag_q && enables_q[sssp_pkg::BIT_RX_EVENT];
    wire periph_req  = tx_req || rx_req;
    wire core_gate   = int_ctrl_q[sssp_pkg::BIT_GLOBAL_EN] && int_ctrl_q[sssp_pkg::BIT_PERIPH_EN];

    assign irq  = periph_req && core_gate;
    assign wake = periph_req && core_sleep;

    // plain software registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            int_ctrl_q    <= sssp_pkg::RST_INT_CTRL;
            flags_spare_q <= sssp_pkg::RST_FLAGS;
            enables_q     <= sssp_pkg::RST_ENABLES;
            priority_q    <= sssp_pkg::RST_PRIORITY;
            rate_div_q    <= sssp_pkg::RST_RATE_DIV;
            txctl_q       <= sssp_pkg::sssp_txctl_s'(sssp_pkg::RST_TX_CTRL);
            rxctl_q       <= sssp_pkg::sssp_rxctl_s'(sssp_pkg::RST_RX_CTRL);
        end else begin
            if (wr_int_ctrl) int_ctrl_q <= reg_wdata;
            if (wr_flags) flags_spare_q <= reg_wdata;
            if (wr_enables) enables_q <= reg_wdata;
            if (wr_priority) priority_q <= reg_wdata;
            if (wr_rate_div) rate_div_q <= reg_wdata;
            if (wr_tx_ctrl) txctl_q <= sssp_pkg::sssp_txctl_s'(reg_wdata);
            if (wr_rx_ctrl) rxctl_q <= sssp_pkg::sssp_rxctl_s'(reg_wdata);
        end
    end

    // transmit buffer and flag; the flag only ever clears on a buffer write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txbuf_q      <= {1'b0, sssp_pkg::RST_TX_BUF};
            txbuf_full_q <= 1'b0;
            transmit_buffer_empty_flag_q       <= 1'b0;
        end else if (wr_tx_buf) begin
            // ninth bit taken from the control register as it stands now
            txbuf_q      <= {txctl_q.transmit_ninth_bit_value, reg_wdata};
            txbuf_full_q <= 1'b1;
            transmit_buffer_empty_flag_q       <= 1'b0;
        end else if (load_go) begin
            txbuf_full_q <= 1'b0;
            transmit_buffer_empty_flag_q       <= 1'b1;
        end
    end

    // transmit shifter: next bit appears after each falling edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tsr_q     <= '0;
            tx_cnt_q  <= '0;
            tx_busy_q <= 1'b0;
        end else if (!tx_on) begin
            tx_cnt_q  <= '0;
            tx_busy_q <= 1'b0;
        end else if (load_go) begin
            tsr_q     <= txbuf_q;
            tx_cnt_q  <= tx_len;
            tx_busy_q <= 1'b1;
        end else if (tx_busy_q && shift_fall) begin
            tsr_q     <= {1'b0, tsr_q[8:1]};
            tx_cnt_q  <= tx_cnt_q - 4'h1;
            tx_busy_q <= !tx_last;
        end
    end

    assign serial_line_out = tsr_q[0];
    assign serial_line_oe  = tx_on && tx_busy_q;

    // receive shifter keeps running through sleep; nothing here looks at sleep
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rsr_q    <= '0;
            rx_cnt_q <= '0;
        end else if (!rx_on) begin
            rx_cnt_q <= '0;
        end else if (rx_shift) begin
            rsr_q    <= rsr_next;
            rx_cnt_q <= rx_done ? 4'h0 : rx_cnt_q + 4'h1;
        end
    end

    // receive buffer, complete flag and overrun; a set beats a read clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rxbuf_q <= sssp_pkg::RST_RX_BUF;
            received_ninth_bit_q  <= 1'b0;
            receive_complete_flag_q  <= 1'b0;
            overrun_error_flag_q  <= 1'b0;
        end else begin
            if (rx_take) begin
                rxbuf_q <= rx_word;
                received_ninth_bit_q  <= rxctl_q.receive_ninth_bit_enable && rsr_next[8];
                receive_complete_flag_q  <= 1'b1;
            end else if (rd_rx_buf) begin
                receive_complete_flag_q  <= 1'b0;
            end
            // the unread word is kept; the new one is dropped
            if (!rx_on) begin
                overrun_error_flag_q  <= 1'b0;
            end else if (rx_done && rx_unread) begin
                overrun_error_flag_q  <= 1'b1;
            end
        end
    end

    // read data: clocked framing never yields a framing error
    wire [7:0] flags_rd = {flags_spare_q[7:6], receive_complete_flag_q, transmit_buffer_empty_flag_q, flags_spare_q[3:0]};
    wire [7:0] txctl_rd = {txctl_q[7:2], !tx_busy_q, txctl_q[0]};
    wire [7:0] rxctl_rd = {rxctl_q[7:3], 1'b0, overrun_error_flag_q, received_ninth_bit_q};
    wire [7:0] rd_mux   = (reg_addr == sssp_pkg::ADDR_INT_CTRL) ? int_ctrl_q :
                          (reg_addr == sssp_pkg::ADDR_FLAGS)    ? flags_rd :
                          (reg_addr == sssp_pkg::ADDR_ENABLES)  ? enables_q :
                          (reg_addr == sssp_pkg::ADDR_PRIORITY) ? priority_q :
                          (reg_addr == sssp_pkg::ADDR_RX_CTRL)  ? rxctl_rd :
                          (reg_addr == sssp_pkg::ADDR_TX_BUF)   ? txbuf_q[7:0] :
                          (reg_addr == sssp_pkg::ADDR_TX_CTRL)  ? txctl_rd :
                          (reg_addr == sssp_pkg::ADDR_RATE_DIV) ? rate_div_q :
                          (reg_addr == sssp_pkg::ADDR_RX_BUF)   ? rxbuf_q : 8'h00;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rd_data_q <= 8'h00;
        end else begin
            rd_data_q <= reg_rd ? rd_mux : 8'h00;
        end
    end

    assign reg_rdata = rd_data_q;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_write_then_quiet;
        wr_tx_buf && tx_on && !tx_busy_q && !txbuf_full_q ##1 !wr_tx_buf && tx_on;
    endsequence

    sequence s_load_with_ninth;
        load_go && txctl_q.transmit_ninth_bit_enable;
    endsequence

    a_buffer_full_clear: assert property (txbuf_full_q |-> !transmit_buffer_empty_flag_q)
        else $error("buffer empty flag set while buffer holds a word");

    a_second_word_load: assert property (load_go |=> tx_busy_q && transmit_buffer_empty_flag_q && !txbuf_full_q)
        else $error("queued word not moved into shifter with flag set");

    a_write_starts_shift: assert property (s_write_then_quiet |=> tx_busy_q && serial_line_oe)
        else $error("buffer write did not start a transmission");

    a_ninth_bit_load: assert property (s_load_with_ninth |=>
                                       tx_cnt_q == 4'h9 && tsr_q[8] == $past(txbuf_q[8]))
        else $error("nine-bit word loaded with wrong length or ninth bit");

    a_transmit_buffer_empty_flag_sticky_flag: assert property (transmit_buffer_empty_flag_q && !wr_tx_buf |=> transmit_buffer_empty_flag_q)
        else $error("buffer empty flag cleared without a buffer write");

    a_mode_drop_idle: assert property (!slave_mode |=> !tx_busy_q && !serial_line_oe && rx_cnt_q == 4'h0)
        else $error("port active outside slave mode");

    a_single_rx_ignored: assert property (!rxctl_q.continuous_receive_enable |=>
                                          rx_cnt_q == 4'h0 && !overrun_error_flag_q)
        else $error("reception advanced without continuous receive");

    a_word_to_buffer: assert property (rx_take |=> receive_complete_flag_q && rxbuf_q == $past(rx_word))
        else $error("completed word not moved into receive buffer");

    a_overrun_sets_flag: assert property (rx_done && rx_unread |=>
                                          overrun_error_flag_q && rxbuf_q == $past(rxbuf_q))
        else $error("overrun not flagged or unread word overwritten");

    a_error_clear_rx: assert property ($fell(rxctl_q.continuous_receive_enable) |-> ##1 !overrun_error_flag_q)
        else $error("receive error survived clearing continuous receive");

    a_rx_sample_fall: assert property (rx_shift |=> rsr_q[8] == $past(pin_level.serial_line))
        else $error("receive bit not taken at the falling shift edge");

    a_wake_in_sleep: assert property (core_sleep && $rose(receive_complete_flag_q) && enables_q[sssp_pkg::BIT_RX_EVENT]
                                      |-> wake)
        else $error("completed reception did not wake the core");

    a_irq_gating: assert property (irq |-> int_ctrl_q[7] && int_ctrl_q[6] && (tx_req || rx_req))
        else $error("interrupt request passed closed enables");

    a_tx_wake_req: assert property (core_sleep && $rose(transmit_buffer_empty_flag_q) && enables_q[sssp_pkg::BIT_TX_EVENT]
                                    |-> wake)
        else $error("buffer empty flag did not wake the core");

endmodule

// >>> tb/sssp_master_model.sv
`timescale 1ns/1ps
module sssp_master_model (
    // pins seen from the far side
    output logic      shift_timing_pin,
    output logic      data_out,
    input  wire logic line
);
    logic d_q;
    logic drive_q;

    initial begin
        shift_timing_pin = 1'b1;
        d_q              = 1'b0;
        drive_q          = 1'b0;
    end

    // released line shows the inverse of the last bit so a stale value never passes
    assign data_out = drive_q ? d_q : ~d_q;

    // one word: data changes on the rising phase, both sides sample at the fall
    task automatic xfer(input int n, input logic drv, input logic [8:0] tx, output logic [8:0] rx);
        rx      = '0;
        drive_q = drv;
        #1.3;
        for (int i = 0; i < n; i++) begin
            d_q = tx[i];
            #32;
            rx[i] = line;
            shift_timing_pin = 1'b0;
            #32;
            shift_timing_pin = 1'b1;
        end
        drive_q = 1'b0;
    endtask
endmodule

// >>> tb/tb_sync_serial_slave_port.sv
`timescale 1ns/1ps
module tb_sync_serial_slave_port;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic [3:0] reg_addr = '0;
    logic [7:0] reg_wdata = '0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic       core_sleep = 1'b0;
    wire  [7:0] reg_rdata;
    wire        irq;
    wire        wake;
    wire        st_pin;
    wire        out;
    wire        oe;
    wire        m_data;
    wire        line;
    logic [8:0] rx;
    int         miscompares = 0;
    int         n_tests = 0;

    always #2 clock = ~clock;
    assign line = oe ? out : m_data;

    sssp_port dut_u (
        .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_sleep(core_sleep), .irq(irq), .wake(wake),
        .shift_timing_pin(st_pin), .serial_line_in(line), .serial_line_out(out), .serial_line_oe(oe)
    );
    sssp_master_model master_u (.shift_timing_pin(st_pin), .data_out(m_data), .line(line));

    task automatic stop_test();
        if (miscompares == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [8:0] got, input logic [8:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] mask);
        logic [7:0] d;
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata & mask;
        chk({1'b0, d}, {1'b0, exp}, "register read");
    endtask

    task automatic t_reset();
        logic [7:0] tab [10];
        tab = '{sssp_pkg::RST_INT_CTRL, sssp_pkg::RST_FLAGS, sssp_pkg::RST_ENABLES, sssp_pkg::RST_PRIORITY,
                sssp_pkg::RST_RX_CTRL, sssp_pkg::RST_TX_BUF, sssp_pkg::RST_TX_CTRL, sssp_pkg::RST_RATE_DIV,
                sssp_pkg::RST_RX_BUF, 8'h00};
        // index 9 is unmapped and reads zero
        for (int a = 0; a < 10; a++)
            rchk(4'(a), tab[a], 8'hff);
    endtask

    task automatic t_tx_sleep();
        wr(sssp_pkg::ADDR_RX_CTRL, 8'h80);
        wr(sssp_pkg::ADDR_TX_CTRL, 8'h30);
        wr(sssp_pkg::ADDR_ENABLES, 8'h10);
        wr(sssp_pkg::ADDR_TX_BUF, 8'ha5);
        tick(3);
        wr(sssp_pkg::ADDR_TX_BUF, 8'h3c);
        core_sleep <= 1'b1;
        rchk(sssp_pkg::ADDR_FLAGS, 8'h00, 8'hff);
        chk({8'h00, oe}, 9'h001, "shifting at once");
        chk({8'h00, wake}, 9'h000, "no early wake");
        master_u.xfer(8, 1'b0, 9'h000, rx);
        chk(rx, 9'h0a5, "first word");
        tick(4);
        chk({8'h00, wake}, 9'h001, "tx wake");
        chk({8'h00, irq}, 9'h000, "irq needs enables");
        rchk(sssp_pkg::ADDR_FLAGS, 8'h10, 8'hff);
        wr(sssp_pkg::ADDR_FLAGS, 8'h00);
        rchk(sssp_pkg::ADDR_FLAGS, 8'h10, 8'hff);
        master_u.xfer(8, 1'b0, 9'h000, rx);
        chk(rx, 9'h03c, "second word");
        tick(4);
        chk({8'h00, oe}, 9'h000, "line released");
        wr(sssp_pkg::ADDR_INT_CTRL, 8'hc0);
        tick(1);
        chk({8'h00, irq}, 9'h001, "irq enabled");
        wr(sssp_pkg::ADDR_INT_CTRL, 8'h80);
        tick(1);
        chk({8'h00, irq}, 9'h000, "irq peripheral off");
        core_sleep <= 1'b0;
        wr(sssp_pkg::ADDR_INT_CTRL, 8'h00);
    endtask

    task automatic t_tx_nine();
        // clock source set means master mode, so a slave shifter must stay idle
        wr(sssp_pkg::ADDR_TX_CTRL, 8'hf1);
        wr(sssp_pkg::ADDR_TX_BUF, 8'h5a);
        tick(8);
        chk({8'h00, oe}, 9'h000, "not slave");
        wr(sssp_pkg::ADDR_TX_CTRL, 8'h71);
        tick(4);
        chk({8'h00, oe}, 9'h001, "slave enabled");
        master_u.xfer(9, 1'b0, 9'h000, rx);
        chk(rx, 9'h15a, "nine bit word");
        wr(sssp_pkg::ADDR_TX_CTRL, 8'h10);
    endtask

    task automatic t_rx();
        wr(sssp_pkg::ADDR_ENABLES, 8'h20);
        wr(sssp_pkg::ADDR_RX_CTRL, 8'ha0);
        master_u.xfer(8, 1'b1, 9'h077, rx);
        tick(6);
        rchk(sssp_pkg::ADDR_FLAGS, 8'h00, 8'h20);
        wr(sssp_pkg::ADDR_RX_CTRL, 8'hb0);
        core_sleep <= 1'b1;
        master_u.xfer(8, 1'b1, 9'h0c3, rx);
        tick(6);
        chk({8'h00, wake}, 9'h001, "rx wake");
        // buffer empty flag is still set from the nine-bit word; only a buffer write clears it
        rchk(sssp_pkg::ADDR_FLAGS, 8'h30, 8'hff);
        rchk(sssp_pkg::ADDR_RX_BUF, 8'hc3, 8'hff);
        rchk(sssp_pkg::ADDR_FLAGS, 8'h10, 8'hff);
        wr(sssp_pkg::ADDR_RX_CTRL, 8'hd0);
        master_u.xfer(9, 1'b1, 9'h13c, rx);
        tick(6);
        rchk(sssp_pkg::ADDR_RX_CTRL, 8'hd1, 8'hff);
        rchk(sssp_pkg::ADDR_RX_BUF, 8'h3c, 8'hff);
        wr(sssp_pkg::ADDR_RX_CTRL, 8'hb0);
        master_u.xfer(8, 1'b1, 9'h011, rx);
        master_u.xfer(8, 1'b1, 9'h022, rx);
        tick(6);
        rchk(sssp_pkg::ADDR_RX_CTRL, 8'h02, 8'h06);
        rchk(sssp_pkg::ADDR_RX_BUF, 8'h11, 8'hff);
        wr(sssp_pkg::ADDR_RX_CTRL, 8'h80);
        rchk(sssp_pkg::ADDR_RX_CTRL, 8'h00, 8'h02);
        core_sleep <= 1'b0;
    endtask

    // about 5 us of traffic; the limit leaves ample margin
    initial begin
        #60000;
        miscompares++;
        stop_test();
    end

    initial begin
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_tx_sleep();
        t_tx_nine();
        t_rx();
        stop_test();
    end
endmodule
